// ---- src/lra_pkg.sv ----
// package: register map, reset values and carrier types of the light/reflect alert block
`default_nettype none
package lra_pkg;
  // register offsets
  localparam logic [7:0] OFF_ALERT    = 8'h04;
  localparam logic [7:0] OFF_RLOW     = 8'h05;
  localparam logic [7:0] OFF_RHIGH    = 8'h06;
  localparam logic [7:0] OFF_LLOWUP   = 8'h07;
  localparam logic [7:0] OFF_LSHARED  = 8'h08;
  localparam logic [7:0] OFF_LHIGHLO  = 8'h09;
  localparam logic [7:0] OFF_RRESULT  = 8'h0A;
  localparam logic [7:0] OFF_LRESUP   = 8'h0B;
  localparam logic [7:0] OFF_LRESLO   = 8'h0C;
  localparam logic [7:0] OFF_AMBIR    = 8'h0D;
  localparam logic [7:0] OFF_RESTART  = 8'h0E;
  // field positions in the alert configuration/status register
  localparam int BIT_RFLAG    = 7;
  localparam int BIT_RPERS_HI = 6;
  localparam int BIT_RPERS_LO = 5;
  localparam int BIT_BROWN    = 4;
  localparam int BIT_LFLAG    = 3;
  localparam int BIT_LPERS_HI = 2;
  localparam int BIT_LPERS_LO = 1;
  localparam int BIT_COMBINE  = 0;
  // reset values
  localparam logic [7:0] RST_ALERT   = 8'h10;
  localparam logic [7:0] RST_RLOW    = 8'h00;
  localparam logic [7:0] RST_RHIGH   = 8'hFF;
  localparam logic [7:0] RST_LLOWUP  = 8'h00;
  localparam logic [7:0] RST_LSHARED = 8'h0F;
  localparam logic [7:0] RST_LHIGHLO = 8'hFF;
  localparam logic [7:0] RESTART_CMD = 8'h38;
  localparam logic [7:0] RESTART_NOP = 8'h00;
  // register access request
  typedef struct packed {
    logic       wrEn;
    logic       rdEn;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lra_req_t;
  // one finished measurement from the front end
  typedef struct packed {
    logic        reflectValid;
    logic [7:0]  reflectResult;
    logic [6:0]  ambientIr;
    logic        washoutStatus;
    logic        lightValid;
    logic [11:0] lightResult;
  } lra_meas_t;
endpackage
`default_nettype wire

// ---- src/lra_persist.sv ----
// persistence counter: qualifies a channel after 1/2/4/8 consecutive flag events
`default_nettype none
module lra_persist #(
  parameter int CW = 4 // counter width, holds up to 8
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       clear,      // soft restart or flag cleared
  input  wire logic       measValid,  // one measurement finished
  input  wire logic       flagEvent,  // that measurement raised a flag
  input  wire logic [1:0] persistSel, // persistence code
  output logic            qualified   // count reached
);
  logic [CW-1:0] count_reg; // consecutive flag events seen
  logic [CW-1:0] target;    // events needed for selected code

  // code 00/01/10/11 -> 1/2/4/8
  assign target = CW'(1) << persistSel;

  // count consecutive events, restart on a clean measurement
  always_ff @(posedge clk) begin
    if (!rst_n || clear) begin
      count_reg <= '0;
    end else if (measValid) begin
      if (!flagEvent) begin
        count_reg <= '0;
      end else if (count_reg < target) begin
        count_reg <= count_reg + CW'(1);
      end
    end
  end

  assign qualified = (count_reg >= target);
endmodule // lra_persist
`default_nettype wire

// ---- src/lra_alert_regs.sv ----
// register bank and alert logic of the light/reflection sensor
// Summary of operation
// [RULE1] reflect persistence 1/2/4/8 events, bits 6:5
// [RULE2] light persistence 1/2/4/8 events, bits 2:1
// [RULE3] combine bit: 1 AND, 0 OR
// [RULE4] reflect event flag at bit 7
// [RULE5] light event flag at bit 3
// [RULE6] brown-out flag bit 4, never alerts
// [RULE7] writing zero to bit 4 clears brown-out
// [RULE8] reflect low threshold 0x05, resets 0x00
// [RULE9] reflect high threshold 0x06, resets 0xFF
// [RULE10] light thresholds packed over 0x07-0x09
// [RULE11] shared light threshold byte resets 0x0F
// [RULE12] reflect result readable at 0x0A
// [RULE13] light result 0x0B low nibble, 0x0C
// [RULE14] ambient infrared level in 0x0D bits 7:1
// [RULE15] washout status in 0x0D bit 0
// [RULE16] host checks washout before trusting result
// [RULE17] writing 0x38 to 0x0E restarts
// [RULE18] light flag set outside thresholds, cleared by zero
// [RULE19] reflect flag above high, cleared below low
// [RULE20] scheme bit: window or hysteresis compare
// [RULE21] alert pin driven after persistence count reached
// [RULE22] clean measurement resets counter; cleared flags release
//
// timing: writes land at the next edge
// read data follows its strobe by one cycle, holds until the next read
// alert path: the measurement edge updates flag and counter,
// the next edge updates the pin enable
// counters: 1/2/4/8 consecutive events per channel
// brown-out flag survives soft restart so supply trouble stays visible
// unmapped offsets read zero and ignore writes
// open drain: the pin value is tied low, the enable pulls it
`default_nettype none
module lra_alert_regs (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire lra_pkg::lra_req_t  req,            // register access from serial slave
  output logic [7:0]              rdata,          // read data, registered
  input  wire lra_pkg::lra_meas_t meas,           // measurement results
  input  wire logic               brownoutEvent,  // supply interruption pulse
  input  wire logic               compareScheme,  // 0 window, 1 hysteresis
  output logic                    alertOut,       // open-drain pin output value (always 0)
  output logic                    alertOe,        // high while pin pulled low
  output logic                    restartPulse    // one-cycle soft restart request
);
  // configuration and flag state
  logic       reflectFlag_reg;   // reflect event flag
  logic       lightFlag_reg;     // light event flag
  logic       brownFlag_reg;     // brown-out flag
  logic [1:0] reflectPers_reg;   // reflect persistence code
  logic [1:0] lightPers_reg;     // light persistence code
  logic       combine_reg;       // pin combine mode
  logic [7:0] rLow_reg;          // reflect low threshold
  logic [7:0] rHigh_reg;         // reflect high threshold
  logic [7:0] lLowUp_reg;        // light low bits 11:4
  logic [7:0] lShared_reg;       // light low 3:0 / high 11:8
  logic [7:0] lHighLo_reg;       // light high bits 7:0
  // result state
  logic [7:0]  rResult_reg;      // latest reflect result
  logic [11:0] lResult_reg;      // latest light result
  logic [6:0]  ambIr_reg;        // ambient infrared level
  logic        wash_reg;         // washout status
  // derived
  logic [11:0] lightLow;         // assembled light low threshold
  logic [11:0] lightHigh;        // assembled light high threshold
  logic        lightOut;         // light result outside window
  logic        reflectAbove;     // reflect result above high
  logic        reflectBelow;     // reflect result below low
  logic        reflectEvent;     // reflect flag event this measurement
  logic        reflectSet;       // flag set request
  logic        reflectClr;       // flag clear by comparison
  logic        lightSet;         // light flag set request
  logic        rClear;           // hold reflect counter at zero
  logic        lClear;           // hold light counter at zero
  logic        alertWr;          // write to alert register
  logic        restart;          // soft restart strobe
  logic        rQual;            // reflect qualified
  logic        lQual;            // light qualified
  logic        assertPin;        // pin should be pulled low

  // decode: true when this cycle writes the given offset
  // one compare shared by every write-enabled register
  function automatic logic isWrite(input lra_pkg::lra_req_t r, input logic [7:0] off);
    return r.wrEn && (r.addr == off);
  endfunction

  // write strobes of the alert register and the restart command
  assign alertWr = isWrite(req, lra_pkg::OFF_ALERT);
  assign restart = isWrite(req, lra_pkg::OFF_RESTART) && (req.wdata == lra_pkg::RESTART_CMD); // [RULE17]
  assign restartPulse = restart;

  // threshold assembly
  // no staging between the three bytes: each write counts at once,
  // so the host updates a pair while the channel is quiet
  assign lightLow  = {lLowUp_reg, lShared_reg[7:4]}; // [RULE10]
  assign lightHigh = {lShared_reg[3:0], lHighLo_reg}; // [RULE10]

  // comparisons
  // strict compares: a result equal to a threshold counts as inside
  // compareScheme is a level from outside, taken as it stands
  assign lightOut     = (meas.lightResult < lightLow) || (meas.lightResult > lightHigh); // [RULE18]
  assign reflectAbove = meas.reflectResult > rHigh_reg;
  assign reflectBelow = meas.reflectResult < rLow_reg;
  // window mode flags either excursion; hysteresis only above high
  assign reflectEvent = compareScheme ? reflectAbove : (reflectAbove || reflectBelow); // [RULE20]
  assign reflectSet   = meas.reflectValid && reflectEvent; // [RULE19]
  assign reflectClr   = meas.reflectValid && compareScheme && reflectBelow; // [RULE19]
  assign lightSet     = meas.lightValid && lightOut; // [RULE18]

  // counters rest at zero while their flag is down, except in the cycle
  // that raises the flag: that measurement is the first event counted
  assign rClear = restart || (!reflectFlag_reg && !reflectSet); // [RULE22]
  assign lClear = restart || (!lightFlag_reg && !lightSet); // [RULE22]

  // configuration fields of alert register
  // restart returns persistence and combine mode to their defaults
  always_ff @(posedge clk) begin
    if (!rst_n || restart) begin
      reflectPers_reg <= lra_pkg::RST_ALERT[lra_pkg::BIT_RPERS_HI:lra_pkg::BIT_RPERS_LO];
      lightPers_reg   <= lra_pkg::RST_ALERT[lra_pkg::BIT_LPERS_HI:lra_pkg::BIT_LPERS_LO];
      combine_reg     <= lra_pkg::RST_ALERT[lra_pkg::BIT_COMBINE];
    end else if (alertWr) begin
      reflectPers_reg <= req.wdata[lra_pkg::BIT_RPERS_HI:lra_pkg::BIT_RPERS_LO]; // [RULE1]
      lightPers_reg   <= req.wdata[lra_pkg::BIT_LPERS_HI:lra_pkg::BIT_LPERS_LO]; // [RULE2]
      combine_reg     <= req.wdata[lra_pkg::BIT_COMBINE]; // [RULE3]
    end
  end

  // reflect flag: set wins over the compare and write-zero clears, restart wins over set
  // hysteresis clears below low; window mode leaves clearing to the host
  // a set and a clear in one cycle leave the flag set
  always_ff @(posedge clk) begin
    if (!rst_n || restart) begin
      reflectFlag_reg <= lra_pkg::RST_ALERT[lra_pkg::BIT_RFLAG];
    end else if (reflectSet) begin
      reflectFlag_reg <= 1'b1; // [RULE4]
    end else if (reflectClr || (alertWr && !req.wdata[lra_pkg::BIT_RFLAG])) begin
      reflectFlag_reg <= 1'b0; // [RULE19]
    end
  end

  // light flag: set wins over write-zero clear
  // writing one to bit 3 leaves the flag as it is
  // an event in the cycle of the clear keeps the flag set
  always_ff @(posedge clk) begin
    if (!rst_n || restart) begin
      lightFlag_reg <= lra_pkg::RST_ALERT[lra_pkg::BIT_LFLAG];
    end else if (lightSet) begin
      lightFlag_reg <= 1'b1; // [RULE5]
    end else if (alertWr && !req.wdata[lra_pkg::BIT_LFLAG]) begin
      lightFlag_reg <= 1'b0; // [RULE18]
    end
  end

  // brown-out flag: set at reset and on supply events, host clears
  // soft restart leaves it alone so the host still learns of the drop
  // an event in the cycle of the clear keeps it set
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      brownFlag_reg <= lra_pkg::RST_ALERT[lra_pkg::BIT_BROWN];
    end else if (brownoutEvent) begin
      brownFlag_reg <= 1'b1; // [RULE6]
    end else if (alertWr && !req.wdata[lra_pkg::BIT_BROWN]) begin
      brownFlag_reg <= 1'b0; // [RULE7]
    end
  end

  // reflect thresholds
  // plain byte registers, both reach the compare at the next edge
  always_ff @(posedge clk) begin
    if (!rst_n || restart) begin
      rLow_reg  <= lra_pkg::RST_RLOW;
      rHigh_reg <= lra_pkg::RST_RHIGH;
    end else begin
      if (isWrite(req, lra_pkg::OFF_RLOW)) begin
        rLow_reg <= req.wdata; // [RULE8]
      end
      if (isWrite(req, lra_pkg::OFF_RHIGH)) begin
        rHigh_reg <= req.wdata; // [RULE9]
      end
    end
  end

  // light thresholds
  // shared byte resets so low starts at zero and high at full scale
  // together with the outer bytes
  always_ff @(posedge clk) begin
    if (!rst_n || restart) begin
      lLowUp_reg  <= lra_pkg::RST_LLOWUP;
      lShared_reg <= lra_pkg::RST_LSHARED; // [RULE11]
      lHighLo_reg <= lra_pkg::RST_LHIGHLO;
    end else begin
      if (isWrite(req, lra_pkg::OFF_LLOWUP)) begin
        lLowUp_reg <= req.wdata; // [RULE10]
      end
      if (isWrite(req, lra_pkg::OFF_LSHARED)) begin
        lShared_reg <= req.wdata; // [RULE10]
      end
      if (isWrite(req, lra_pkg::OFF_LHIGHLO)) begin
        lHighLo_reg <= req.wdata; // [RULE10]
      end
    end
  end

  // capture reflect result and ambient infrared
  // washout is taken with the result that it qualifies,
  // so one read of the ambient byte tells whether the result holds
  always_ff @(posedge clk) begin
    if (!rst_n || restart) begin
      rResult_reg <= 8'h00;
      ambIr_reg   <= 7'h00;
      wash_reg    <= 1'b0;
    end else if (meas.reflectValid) begin
      rResult_reg <= meas.reflectResult; // [RULE12]
      ambIr_reg   <= meas.ambientIr; // [RULE14]
      wash_reg    <= meas.washoutStatus; // [RULE15]
    end
  end

  // capture light result
  // all twelve bits land together; reads of the two bytes may straddle
  // a new result, there is no latching between them
  always_ff @(posedge clk) begin
    if (!rst_n || restart) begin
      lResult_reg <= 12'h000;
    end else if (meas.lightValid) begin
      lResult_reg <= meas.lightResult; // [RULE13]
    end
  end

  // persistence counters, cleared by restart or when the flag drops
  // one counter per channel, each with its own persistence code
  // a host flag clear empties the counter one edge later
  lra_persist #(.CW(4)) uReflectPers (
    .clk        (clk),
    .rst_n      (rst_n),
    .clear      (rClear),
    .measValid  (meas.reflectValid),
    .flagEvent  (reflectEvent),
    .persistSel (reflectPers_reg),
    .qualified  (rQual)
  ); // [RULE1] [RULE21] [RULE22]

  lra_persist #(.CW(4)) uLightPers (
    .clk        (clk),
    .rst_n      (rst_n),
    .clear      (lClear),
    .measValid  (meas.lightValid),
    .flagEvent  (lightOut),
    .persistSel (lightPers_reg),
    .qualified  (lQual)
  ); // [RULE2] [RULE21] [RULE22]

  // combine qualified channels; brown-out never participates
  // each term also needs its flag, so a host clear drops the pin at once
  // without waiting for the counter to follow
  always_comb begin
    if (combine_reg) begin
      assertPin = rQual && lQual && reflectFlag_reg && lightFlag_reg; // [RULE3]
    end else begin
      assertPin = (rQual && reflectFlag_reg) || (lQual && lightFlag_reg); // [RULE3] [RULE6]
    end
  end

  // pin pulled low through its enable
  // registered so compare glitches never reach the pin
  // enable is low through reset, so the pin starts released
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      alertOe <= 1'b0;
    end else begin
      alertOe <= assertPin; // [RULE21] [RULE22]
    end
  end
  assign alertOut = 1'b0;

  // registered read data
  // holds the last answer until the next read strobe
  // unmapped offsets and the restart command read as zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (req.rdEn) begin
      case (req.addr)
        lra_pkg::OFF_ALERT:   rdata <= {reflectFlag_reg, reflectPers_reg, brownFlag_reg,
                                        lightFlag_reg, lightPers_reg, combine_reg}; // [RULE4] [RULE5]
        lra_pkg::OFF_RLOW:    rdata <= rLow_reg;
        lra_pkg::OFF_RHIGH:   rdata <= rHigh_reg;
        lra_pkg::OFF_LLOWUP:  rdata <= lLowUp_reg;
        lra_pkg::OFF_LSHARED: rdata <= lShared_reg;
        lra_pkg::OFF_LHIGHLO: rdata <= lHighLo_reg;
        lra_pkg::OFF_RRESULT: rdata <= rResult_reg; // [RULE12]
        lra_pkg::OFF_LRESUP:  rdata <= {4'h0, lResult_reg[11:8]}; // [RULE13]
        lra_pkg::OFF_LRESLO:  rdata <= lResult_reg[7:0]; // [RULE13]
        lra_pkg::OFF_AMBIR:   rdata <= {ambIr_reg, wash_reg}; // [RULE14] [RULE15]
        lra_pkg::OFF_RESTART: rdata <= lra_pkg::RESTART_NOP; // [RULE17]
        default:              rdata <= 8'h00;
      endcase
    end
  end
endmodule // lra_alert_regs
`default_nettype wire

// ---- sim/lra_alert_monitor.sv ----
// checker: timing relations on the ports of the alert register block
`default_nettype none
module lra_alert_monitor (
  input wire logic               clk,
  input wire logic               rst_n,
  input wire lra_pkg::lra_req_t  req,
  input wire logic [7:0]         rdata,
  input wire lra_pkg::lra_meas_t meas,
  input wire logic               brownoutEvent,
  input wire logic               compareScheme,
  input wire logic               alertOut,
  input wire logic               alertOe,
  input wire logic               restartPulse
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [15:0] lastRefl; // last reflect result and ambient byte
  // mirror of the reflect result registers
  always_ff @(posedge clk) begin
    if (!rst_n || restartPulse) lastRefl <= 16'h0000;
    else if (meas.reflectValid)
      lastRefl <= {meas.reflectResult, meas.ambientIr, meas.washoutStatus};
  end
  pin_low_a: assert property (alertOut == 1'b0)
    else $error("alert pin value not low");
  restart_decode_a: assert property (
    restartPulse == (req.wrEn && req.addr == 8'h0E && req.wdata == 8'h38))
    else $error("restart pulse wrong");
  restart_reads_zero_a: assert property (
    req.rdEn && req.addr == 8'h0E |=> rdata == 8'h00) else $error("restart reg not zero");
  light_upper_zero_a: assert property (
    req.rdEn && req.addr == 8'h0B |=> rdata[7:4] == 4'h0) else $error("upper nibble set");
  reflect_readback_a: assert property (
    req.rdEn && req.addr == 8'h0A && !meas.reflectValid |=> rdata == $past(lastRefl[15:8]))
    else $error("reflect result wrong");
  ambient_readback_a: assert property (
    req.rdEn && req.addr == 8'h0D && !meas.reflectValid |=> rdata == $past(lastRefl[7:0]))
    else $error("ambient byte wrong");
  flag_release_a: assert property (
    req.wrEn && req.addr == 8'h04 && !req.wdata[7] && !req.wdata[3]
    && !meas.reflectValid && !meas.lightValid |-> ##[1:3] !alertOe)
    else $error("alert held after flags cleared");
  restart_release_a: assert property (restartPulse |-> ##[1:3] !alertOe)
    else $error("alert held after restart");
  alert_cause_a: assert property (
    $rose(alertOe) |-> $past(meas.reflectValid, 2) || $past(meas.lightValid, 2)
    || $past(req.wrEn, 2))
    else $error("alert without measurement");
  cover property ($rose(alertOe));
  cover property (restartPulse);
  cover property (meas.lightValid ##2 alertOe);
endmodule // lra_alert_monitor
bind lra_alert_regs lra_alert_monitor i_lra_alert_monitor (.clk(clk), .rst_n(rst_n),
  .req(req), .rdata(rdata), .meas(meas), .brownoutEvent(brownoutEvent),
  .compareScheme(compareScheme), .alertOut(alertOut), .alertOe(alertOe),
  .restartPulse(restartPulse));
`default_nettype wire

// ---- sim/lra_host_model.sv ----
// host model: byte read and write cycles on the register request port
`default_nettype none
module lra_host_model (
  input  wire logic        clk,
  input  wire logic [7:0]  rdata,
  output var lra_pkg::lra_req_t req
);
  timeunit 1ns;
  timeprecision 1ps;
  initial req = '0;
  // write: strobe held across one rising edge, idle lines inverted after
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk) req <= '{1'b1, 1'b0, a, d};
    @(negedge clk) req <= '{1'b0, 1'b0, ~a, ~d};
  endtask
  // read: data taken once the registered answer has landed
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk) req <= '{1'b0, 1'b1, a, 8'h00};
    @(negedge clk) req <= '{1'b0, 1'b0, ~a, 8'hFF};
    d = rdata;
  endtask
endmodule // lra_host_model
`default_nettype wire

// ---- sim/tb.sv ----
// testbench: register map, flags, persistence and restart of the alert block
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic               clk = 1'b0;           // 250 MHz
  logic               rst_n = 1'b0;         // synchronous reset
  lra_pkg::lra_req_t  req;                  // from host model
  logic [7:0]         rdata;                // read data
  lra_pkg::lra_meas_t meas = '0;            // measurement input
  logic               brownoutEvent = 1'b0; // supply drop pulse
  logic               compareScheme = 1'b0; // 0 window
  logic               alertOut;             // pin value
  logic               alertOe;              // pin pulled low
  logic               restartPulse;         // restart request
  logic [7:0]         v;                    // read scratch
  logic [7:0]         cfg;                  // alert config byte
  logic [7:0]         rstv [6] = '{8'h10, 8'h00, 8'hFF, 8'h00, 8'h0F, 8'hFF};
  logic [7:0]         thr [5] = '{8'h40, 8'h80, 8'h10, 8'h02, 8'h00};
  logic [11:0]        hv [4] = '{12'h030, 12'h390, 12'h160, 12'h030};
  logic [7:0]         he [4] = '{8'h00, 8'h80, 8'h80, 8'h00};
  int                 fails = 0;
  int                 n_tests = 0;
  always #2 clk = ~clk;
  lra_host_model i_lra_host_model (.clk(clk), .rdata(rdata), .req(req));
  lra_alert_regs i_lra_alert_regs (.clk(clk), .rst_n(rst_n), .req(req), .rdata(rdata),
    .meas(meas), .brownoutEvent(brownoutEvent), .compareScheme(compareScheme),
    .alertOut(alertOut), .alertOe(alertOe), .restartPulse(restartPulse));
  // compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // read a register and compare
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    i_lra_host_model.rd(a, v);
    chk(v, exp);
  endtask
  // one measurement, ch 0 light, 1 reflect; returns once the pin has settled
  task automatic measure(input bit ch, input logic [11:0] x);
    @(negedge clk) meas <= ch ? '{1'b1, x[7:0], 7'h55, 1'b1, 1'b0, 12'h000}
                              : '{1'b0, 8'h00, 7'h00, 1'b0, 1'b1, x};
    @(negedge clk) meas.reflectValid <= 1'b0;
    meas.lightValid <= 1'b0;
    @(negedge clk);
  endtask
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // hang guard
  initial begin
    #200000;
    fails++;
    stop_test();
  end
  initial begin
    repeat (2) @(negedge clk);
    rst_n <= 1'b1;
    // reset values, restart register and an unmapped place
    foreach (rstv[i]) rchk(8'h04 + 8'(i), rstv[i]);
    rchk(8'h0E, 8'h00);
    rchk(8'h0F, 8'h00);
    // brown-out cleared by zero, set again without alert
    i_lra_host_model.wr(8'h04, 8'h00);
    rchk(8'h04, 8'h00);
    @(negedge clk) brownoutEvent <= 1'b1;
    @(negedge clk) brownoutEvent <= 1'b0;
    rchk(8'h04, 8'h10);
    chk({7'h00, alertOe}, 8'h00);
    // thresholds: reflect 0x40/0x80, light 0x100/0x200
    foreach (thr[i]) i_lra_host_model.wr(8'h05 + 8'(i), thr[i]);
    foreach (thr[i]) rchk(8'h05 + 8'(i), thr[i]);
    // every persistence code on both channels, clean sample restarts count
    for (int ch = 0; ch < 2; ch++) begin
      for (int c = 0; c < 4; c++) begin
        cfg = 8'(c << (ch == 1 ? 5 : 1));
        i_lra_host_model.wr(8'h04, cfg);
        repeat ((1 << c) - 1) measure(ch[0], 12'h390);
        measure(ch[0], 12'h160);
        repeat ((1 << c) - 1) measure(ch[0], 12'h390);
        chk({7'h00, alertOe}, 8'h00);
        measure(ch[0], 12'h390);
        chk({7'h00, alertOe}, 8'h01);
        rchk(8'h04, cfg | (ch == 1 ? 8'h80 : 8'h08));
      end
    end
    // window mode: below low sets the flag
    i_lra_host_model.wr(8'h04, 8'h00);
    measure(1'b1, 12'h030);
    rchk(8'h04, 8'h80);
    // hysteresis: set above high, kept in band, cleared below low
    compareScheme <= 1'b1;
    i_lra_host_model.wr(8'h04, 8'h00);
    foreach (hv[i]) begin
      measure(1'b1, hv[i]);
      rchk(8'h04, he[i]);
    end
    // combine bit set: both channels needed
    i_lra_host_model.wr(8'h04, 8'h01);
    measure(1'b0, 12'h390);
    chk({7'h00, alertOe}, 8'h00);
    measure(1'b1, 12'h390);
    chk({7'h00, alertOe}, 8'h01);
    // result registers, washout checked first
    rchk(8'h0D, 8'hAB);
    rchk(8'h0A, 8'h90);
    rchk(8'h0B, 8'h03);
    rchk(8'h0C, 8'h90);
    // wrong restart code ignored, right one restores defaults, brown-out kept
    @(negedge clk) brownoutEvent <= 1'b1;
    @(negedge clk) brownoutEvent <= 1'b0;
    i_lra_host_model.wr(8'h0E, 8'h11);
    rchk(8'h05, 8'h40);
    i_lra_host_model.wr(8'h0E, 8'h38);
    rchk(8'h05, 8'h00);
    rchk(8'h04, 8'h10);
    chk({7'h00, alertOe}, 8'h00);
    stop_test();
  end
endmodule // tb
`default_nettype wire
